// ### rtc_calendar.sv
// Purpose: seconds-driven time counter with carry through all fields
// Assumes: tick is a one-cycle pulse once a second
// Notes: a pending load replaces the increment on the tick
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic cal_mode,
  input wire logic load,
  input wire rtc_pkg::rtc_time_t load_val,
  output rtc_pkg::rtc_time_t now
);
  import rtc_pkg::*;

  rtc_time_t next_now;

  // wrap detection, >= so an out-of-range load still wraps
  wire sec_wrap = now.second >= SEC_MAX;
  wire min_wrap = now.minute >= MIN_MAX;
  wire hour_wrap = now.hour >= HOUR_MAX;
  wire day_wrap = now.day >= DAY_MAX;
  wire month_wrap = now.month >= MONTH_MAX;
  wire year_wrap = now.year >= YEAR_MAX;

  // carry chain; elapsed mode counts days and months from zero
  wire min_step = sec_wrap;
  wire hour_step = min_step & min_wrap;
  wire day_step = hour_step & hour_wrap;
  wire month_step = day_step & day_wrap;
  wire year_step = month_step & month_wrap;
  wire [4:0] day_low = cal_mode ? DAY_MIN_CAL : 5'h00;
  wire [3:0] month_low = cal_mode ? MONTH_MIN_CAL : 4'h0;

  // next value for one tick
  assign next_now.second = sec_wrap ? 6'h00 : now.second + 6'h01;
  assign next_now.minute = !min_step ? now.minute : (min_wrap ? 6'h00 : now.minute + 6'h01);
  assign next_now.hour = !hour_step ? now.hour : (hour_wrap ? 5'h00 : now.hour + 5'h01);
  assign next_now.day = !day_step ? now.day : (day_wrap ? day_low : now.day + 5'h01);
  assign next_now.month = !month_step ? now.month
                        : (month_wrap ? month_low : now.month + 4'h1);
  assign next_now.year = !year_step ? now.year : (year_wrap ? 7'h00 : now.year + 7'h01);

  // live time: cleared by reset, loaded or advanced on the tick
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      now <= '0;
    end else if (tick) begin
      now <= load ? load_val : next_now;
    end
  end

endmodule : rtc_calendar
`default_nettype wire

// ### rtc_host_model.sv
// Purpose: host model, serial master in mode 3 sending 16-bit words
// Assumes: link half period of 16 core cycles, a 160 ns link period
// Notes: mosi is inverted between frames so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
  input wire logic core_clk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  import rtc_pkg::*;
  logic [15:0] rx;
  // link idles with clock high and chip select off
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // one frame: word out msb first, answer to the previous word comes back
  task automatic xfer(input logic [15:0] wd, output logic [15:0] rd);
    spi_cs_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk <= 1'b0;
      spi_mosi <= wd[i];
      repeat (16) @(posedge core_clk);
      rx[i] = spi_miso_oe ? spi_miso : 1'bx;
      spi_sclk <= 1'b1;
      repeat (16) @(posedge core_clk);
    end
    spi_cs_n <= 1'b1;
    spi_mosi <= ~wd[0];
    repeat (8) @(posedge core_clk);
    rd = rx;
  endtask : xfer
  // control page write pair, leaves page 3 selected
  task automatic ctl_write(input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] d;
    xfer(16'h8003, d);
    xfer(lo, d);
    xfer(hi, d);
  endtask : ctl_write
  // time load in field order, year byte last to commit
  task automatic load_time(input rtc_time_t t);
    logic [15:0] d;
    xfer({8'hf8, 2'b00, t.second}, d);
    xfer({8'hf9, 2'b00, t.minute}, d);
    xfer({8'hfa, 3'b000, t.hour}, d);
    xfer({8'hfb, 3'b000, t.day}, d);
    xfer({8'hfc, 4'h0, t.month}, d);
    xfer({8'hfd, 1'b0, t.year}, d);
  endtask : load_time
endmodule : rtc_host_model
`default_nettype wire

// ### rtc_pkg.sv
// Purpose: shared constants, field layouts and carriers for the timekeeper block
// Assumes: 16-bit serial words, byte addresses, 200 MHz core clock
// Notes: register words pair an even (low byte) and odd (high byte) address
package rtc_pkg;

  // clock and seconds tick timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SECOND_NS = 1_000_000_000;
  localparam int unsigned TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  // serial word layout
  localparam int unsigned WORD_BITS = 16;
  localparam logic [4:0] LAST_BIT = 5'h0f;

  // pages and byte addresses
  localparam logic [15:0] PAGE_RESET = 16'h0000;
  localparam logic [15:0] PAGE_TIME = 16'h0000;
  localparam logic [15:0] PAGE_CTRL = 16'h0003;
  localparam logic [6:0] ADDR_PAGE = 7'h00;
  localparam logic [6:0] ADDR_GCMD = 7'h02;
  localparam logic [6:0] ADDR_CFG = 7'h0a;
  localparam logic [6:0] ADDR_MS = 7'h78;
  localparam logic [6:0] ADDR_DH = 7'h7a;
  localparam logic [6:0] ADDR_YM = 7'h7c;

  // configuration and global command fields
  localparam logic [15:0] CFG_RESET = 16'h00c0;
  localparam int unsigned CFG_MODE_POS = 0;
  localparam int unsigned GCMD_SAVE_POS = 2; // bit that the save command byte 0x04 sets

  // time field positions inside the 16-bit registers
  localparam int unsigned SEC_POS = 0;
  localparam int unsigned MIN_POS = 8;
  localparam int unsigned HOUR_POS = 0;
  localparam int unsigned DAY_POS = 8;
  localparam int unsigned MONTH_POS = 0;
  localparam int unsigned YEAR_POS = 8;

  // field range limits
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [4:0] DAY_MAX = 5'h1f;
  localparam logic [4:0] DAY_MIN_CAL = 5'h01;
  localparam logic [3:0] MONTH_MAX = 4'hc;
  localparam logic [3:0] MONTH_MIN_CAL = 4'h1;
  localparam logic [6:0] YEAR_MAX = 7'h63;

  // one decoded serial word
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } spi_cmd_t;

  // full time value
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtc_time_t;

endpackage : rtc_pkg

// ### rtc_spi_port.sv
// Purpose: serial slave, clock polarity high, data taken on rising clock edge
// Assumes: link pins are asynchronous to core_clk and far slower than it
// Notes: a frame cut short by chip select is dropped
`timescale 1ns/1ps
`default_nettype none
module rtc_spi_port (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic [15:0] tx_word,
  output logic cmd_valid,
  output rtc_pkg::spi_cmd_t cmd,
  output logic spi_miso,
  output logic spi_miso_oe
);
  import rtc_pkg::*;

  logic sclk_m, sclk_s, sclk_d;
  logic cs_m, cs_s, cs_d;
  logic mosi_m, mosi_s;
  logic [14:0] shift_in;
  logic [15:0] shift_out;
  logic [4:0] bit_cnt;

  // two-stage synchronisers, then one delay stage for edges
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      {sclk_m, sclk_s, sclk_d} <= 3'h7;
      {cs_m, cs_s, cs_d} <= 3'h7;
      {mosi_m, mosi_s} <= 2'h0;
    end else begin
      {sclk_m, sclk_s, sclk_d} <= {spi_sclk, sclk_m, sclk_s};
      {cs_m, cs_s, cs_d} <= {spi_cs_n, cs_m, cs_s};
      {mosi_m, mosi_s} <= {spi_mosi, mosi_m};
    end
  end

  // edge events inside a selected frame
  wire sclk_rise = sclk_s & ~sclk_d & ~cs_s;
  wire sclk_fall = ~sclk_s & sclk_d & ~cs_s;
  wire frame_start = ~cs_s & cs_d;
  wire word_done = sclk_rise & (bit_cnt == LAST_BIT);

  // receive shifter and bit counter
  always_ff @(posedge core_clk) begin
    if (!nrst || cs_s) begin
      bit_cnt <= 5'h00;
      shift_in <= 15'h0000;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[13:0], mosi_s};
      bit_cnt <= word_done ? 5'h00 : bit_cnt + 5'h01;
    end
  end

  // word split into flag, address and data
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cmd_valid <= 1'b0;
      cmd <= '0;
    end else begin
      cmd_valid <= word_done;
      if (word_done) begin
        cmd <= spi_cmd_t'({shift_in, mosi_s});
      end
    end
  end

  // transmit shifter, changes on falling clock edges
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      shift_out <= 16'h0000;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= ~cs_s;
      if (frame_start) begin
        shift_out <= tx_word;
      end else if (sclk_fall) begin
        spi_miso <= shift_out[15];
        shift_out <= {shift_out[14:0], 1'b0};
      end
    end
  end

endmodule : rtc_spi_port
`default_nettype wire

// ### rtc_timekeeper.sv
// Purpose: real-time clock with page select, reached over the serial port
// Assumes: main_ready marks full startup of the main device, asynchronous
// Notes: time keeps counting whatever main_ready shows; access needs it high
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Configuration bit zero picks elapsed-timer or clock/calendar counting.
// - In elapsed-timer mode all time fields start at zero after reset and count up.
// - Time writes are staged and applied together only after the year byte write.
// - After that year write the old time shows until the next seconds tick loads the new.
// - The save words 0x8003, 0x8204, 0x8300 make the device back up its configuration.
// - Time runs regardless, but register access waits for full startup of the device.
// - Minutes sit in bits 13:8 and seconds in bits 5:0, both 0 to 59, others zero.
// - Day 1 to 31 sits in the upper field and hour 0 to 23 in the lower field.
// - Year 0 to 99 sits in bits 14:8 and month 1 to 12 in bits 3:0, others zero.
// - The page register reads back the page and a write selects it for later accesses.
module rtc_timekeeper #(
  parameter int unsigned TICK_LEN = rtc_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic main_ready,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic config_save,
  output logic [15:0] nv_config,
  output logic [15:0] page_select
);
  import rtc_pkg::*;

  logic ready_m, ready_s;
  logic cmd_valid;
  spi_cmd_t cmd;
  logic [15:0] tx_word;
  logic [15:0] config_reg;
  logic [27:0] tick_cnt;
  logic sec_tick;
  logic commit_pending;
  rtc_time_t staged;
  rtc_time_t live;

  // startup indication synchroniser
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ready_m <= 1'b0;
      ready_s <= 1'b0;
    end else begin
      ready_m <= main_ready;
      ready_s <= ready_m;
    end
  end

  rtc_spi_port u_spi (
    .core_clk(core_clk),
    .nrst(nrst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .tx_word(tx_word),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe)
  );

  // seconds tick divider
  wire tick_wrap = tick_cnt == 28'(TICK_LEN - 1);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tick_cnt <= 28'h0000000;
      sec_tick <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? 28'h0000000 : tick_cnt + 28'h0000001;
      sec_tick <= tick_wrap;
    end
  end

  // word acceptance, only after full startup
  wire accept = cmd_valid & ready_s;
  wire do_wr = accept & cmd.wr;
  wire do_rd = accept & ~cmd.wr;
  wire hi_byte = cmd.addr[0];
  wire [6:0] word_addr = {cmd.addr[6:1], 1'b0};
  wire on_time_page = page_select == PAGE_TIME;
  wire on_ctrl_page = page_select == PAGE_CTRL;
  wire hit_page = word_addr == ADDR_PAGE;
  wire hit_ms = on_time_page & (word_addr == ADDR_MS);
  wire hit_dh = on_time_page & (word_addr == ADDR_DH);
  wire hit_ym = on_time_page & (word_addr == ADDR_YM);
  wire hit_cfg = on_ctrl_page & (word_addr == ADDR_CFG);
  wire hit_gcmd = on_ctrl_page & (word_addr == ADDR_GCMD);

  // write strobes per byte
  wire wr_page_lo = do_wr & hit_page & ~hi_byte;
  wire wr_page_hi = do_wr & hit_page & hi_byte;
  wire wr_year = do_wr & hit_ym & hi_byte;
  wire wr_cfg_lo = do_wr & hit_cfg & ~hi_byte;
  wire wr_cfg_hi = do_wr & hit_cfg & hi_byte;
  wire wr_save = do_wr & hit_gcmd & ~hi_byte & cmd.data[GCMD_SAVE_POS];

  // page select, steers every later time and control page access
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      page_select <= PAGE_RESET;
    end else if (wr_page_lo) begin
      page_select[7:0] <= cmd.data;
    end else if (wr_page_hi) begin
      page_select[15:8] <= cmd.data;
    end
  end

  // configuration register, bit zero chooses the counting mode
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      config_reg <= CFG_RESET;
    end else if (wr_cfg_lo) begin
      config_reg[7:0] <= cmd.data;
    end else if (wr_cfg_hi) begin
      config_reg[15:8] <= cmd.data;
    end
  end
  wire cal_mode = config_reg[CFG_MODE_POS];

  // configuration backup to non-volatile storage
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      config_save <= 1'b0;
      nv_config <= CFG_RESET;
    end else begin
      config_save <= wr_save;
      if (wr_save) begin
        nv_config <= config_reg;
      end
    end
  end

  // staging of host time writes, inactive until committed
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      staged <= '0;
    end else if (do_wr) begin
      if (hit_ms & ~hi_byte) staged.second <= cmd.data[5:0];
      if (hit_ms & hi_byte) staged.minute <= cmd.data[5:0];
      if (hit_dh & ~hi_byte) staged.hour <= cmd.data[4:0];
      if (hit_dh & hi_byte) staged.day <= cmd.data[4:0];
      if (hit_ym & ~hi_byte) staged.month <= cmd.data[3:0];
      if (wr_year) staged.year <= cmd.data[6:0];
    end
  end

  // commit flag: a year write arms it, the tick consumes it; set wins
  wire next_pending = wr_year | (commit_pending & ~sec_tick);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      commit_pending <= 1'b0;
    end else begin
      commit_pending <= next_pending;
    end
  end

  rtc_calendar u_cal (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(sec_tick),
    .cal_mode(cal_mode),
    .load(commit_pending),
    .load_val(staged),
    .now(live)
  );

  // packed register images, unused bits read as zero
  wire [15:0] ms_word = (16'(live.minute) << MIN_POS) | (16'(live.second) << SEC_POS);
  wire [15:0] dh_word = (16'(live.day) << DAY_POS) | (16'(live.hour) << HOUR_POS);
  wire [15:0] ym_word = (16'(live.year) << YEAR_POS) | (16'(live.month) << MONTH_POS);

  // read selection, unmapped addresses answer zero
  wire [15:0] rd_word = hit_page ? page_select
                      : hit_ms ? ms_word
                      : hit_dh ? dh_word
                      : hit_ym ? ym_word
                      : hit_cfg ? config_reg
                      : 16'h0000;

  // answer word, sent in the frame after the read
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_word <= 16'h0000;
    end else if (cmd_valid) begin
      tx_word <= do_rd ? rd_word : 16'h0000;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence seq_year_write;
    wr_year ##1 commit_pending;
  endsequence

  sequence seq_tick_load;
    sec_tick && commit_pending ##1 (live == $past(staged));
  endsequence

  chk_mode_write: assert property (
    wr_cfg_lo |=> cal_mode == $past(cmd.data[0]))
    else $error("mode bit did not follow configuration write");

  chk_reset_zero: assert property (
    $rose(nrst) |-> (live == '0) && !commit_pending)
    else $error("time not zero after reset");

  chk_commit_arm: assert property (
    wr_year |-> seq_year_write)
    else $error("year write did not arm commit");

  chk_commit_load: assert property (
    sec_tick && commit_pending && !wr_year |-> seq_tick_load)
    else $error("staged time not loaded on tick");

  chk_hold_old: assert property (
    !sec_tick |=> $stable(live))
    else $error("time changed without tick");

  chk_save_copy: assert property (
    wr_save |=> config_save && (nv_config == $past(config_reg)))
    else $error("configuration backup missing");

  chk_not_ready: assert property (
    cmd_valid && !ready_s |=> $stable(page_select) && $stable(config_reg) && $stable(staged)
      && (tx_word == 16'h0000))
    else $error("access taken before startup");

  chk_ms_range: assert property (
    live.second <= SEC_MAX && live.minute <= MIN_MAX
      && ms_word[15:14] == 2'h0 && ms_word[7:6] == 2'h0)
    else $error("unused minute/second bits set");

  chk_dh_range: assert property (
    live.hour <= HOUR_MAX && dh_word[15:13] == 3'h0)
    else $error("hour out of range or unused bits set");

  chk_ym_range: assert property (
    live.month <= MONTH_MAX && ym_word[15] == 1'b0 && ym_word[7:4] == 4'h0)
    else $error("month out of range or unused bits set");

  chk_page_write: assert property (
    wr_page_lo |=> page_select[7:0] == $past(cmd.data))
    else $error("page select not written");

  chk_sec_wrap: assert property (
    sec_tick && !commit_pending && live.second == SEC_MAX |=> live.second == 6'h00)
    else $error("seconds did not wrap");

  chk_save_pulse: assert property (
    config_save |=> !config_save)
    else $error("backup pulse longer than one cycle");

  chk_backup_hold: assert property (
    !wr_save |=> $stable(nv_config))
    else $error("backup copy changed without a save");

  chk_tick_single: assert property (
    sec_tick |=> !sec_tick)
    else $error("seconds tick longer than one cycle");

  chk_page_hold: assert property (
    !wr_page_lo && !wr_page_hi |=> $stable(page_select))
    else $error("page select changed without a write");

  chk_cfg_hold: assert property (
    !wr_cfg_lo && !wr_cfg_hi |=> $stable(config_reg))
    else $error("configuration changed without a write");

  chk_staged_hold: assert property (
    !do_wr |=> $stable(staged))
    else $error("staged time changed without a write");

  chk_arm_year: assert property (
    !wr_year && !commit_pending |=> !commit_pending)
    else $error("commit armed without a year write");

  chk_commit_clear: assert property (
    sec_tick && !wr_year |=> !commit_pending)
    else $error("commit flag not consumed by the tick");

  chk_write_answer: assert property (
    do_wr |=> tx_word == 16'h0000)
    else $error("write answered with a nonzero word");

  // top of the calendar and the value one tick later
  wire at_top = live == {YEAR_MAX, MONTH_MAX, DAY_MAX, HOUR_MAX, MIN_MAX, SEC_MAX};
  wire [32:0] wrapped = {7'h00, MONTH_MIN_CAL, DAY_MIN_CAL, 5'h00, 6'h00, 6'h00};

  sequence seq_top_tick;
    sec_tick && !commit_pending && cal_mode && at_top;
  endsequence

  chk_full_wrap: assert property (
    seq_top_tick |=> live == wrapped)
    else $error("calendar did not wrap from its top value");

endmodule : rtc_timekeeper
`default_nettype wire

// ### rtc_timekeeper_test.sv
// Purpose: self-checking bench for the timekeeper block
// Assumes: seconds tick shortened to 1000 core cycles
// Notes: time reads allow a tick of slack for frame latency
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module rtc_timekeeper_test;
  import rtc_pkg::*;
  localparam int unsigned TL = 1000;
  logic core_clk, nrst, main_ready, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic config_save;
  logic [15:0] nv_config, page_select, rd;
  int err_total, num_checks, saves, cyc, s;

  rtc_timekeeper #(.TICK_LEN(TL)) DUT (.core_clk(core_clk), .nrst(nrst),
    .main_ready(main_ready), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .config_save(config_save), .nv_config(nv_config), .page_select(page_select));
  rtc_host_model host (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

  // 200 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // count backup pulses and cycles since reset release
  always @(posedge core_clk) begin
    if (config_save === 1'b1) saves++;
    cyc <= nrst ? cyc + 1 : 0;
  end

  task automatic wr(input logic [15:0] w);
    logic [15:0] d;
    host.xfer(w, d);
  endtask : wr
  // read needs a second frame to carry the answer back
  task automatic rd_reg(input logic [6:0] a, output logic [15:0] v);
    logic [15:0] d;
    host.xfer({1'b0, a, 8'h00}, d);
    host.xfer(16'h0000, v);
  endtask : rd_reg

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // outputs right after reset
  task automatic t_reset();
    `CHK("page", 16'h0000, page_select)
    `CHK("nvcfg", 16'h00c0, nv_config)
    `CHK("save", 1'b0, config_save)
  endtask : t_reset
  // words before full startup change nothing and answer zero
  task automatic t_not_ready();
    main_ready <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr(16'h8002);
    `CHK("page_nr", 16'h0000, page_select)
    rd_reg(ADDR_PAGE, rd);
    `CHK("rd_nr", 16'h0000, rd)
    main_ready <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : t_not_ready
  // page write, read back from both byte addresses
  task automatic t_page();
    wr(16'h8002);
    `CHK("page", 16'h0002, page_select)
    rd_reg(ADDR_PAGE, rd);
    `CHK("page_rd", 16'h0002, rd)
    rd_reg(7'h01, rd);
    `CHK("page_odd", 16'h0002, rd)
    wr(16'h8000);
    `CHK("page0", 16'h0000, page_select)
  endtask : t_page
  // elapsed timer counts from zero since reset
  task automatic t_elapsed();
    s = (cyc + 540) / TL;
    rd_reg(ADDR_MS, rd);
    `CHK("ms_hi", 10'h000, rd[15:6])
    `CHK("sec_el", 1'b1, (rd[5:0] >= s - 1) && (rd[5:0] <= s + 1))
    rd_reg(ADDR_DH, rd);
    `CHK("dh_el", 16'h0000, rd)
    rd_reg(ADDR_YM, rd);
    `CHK("ym_el", 16'h0000, rd)
  endtask : t_elapsed
  // calendar mode, backup, control page reads, unmapped places
  task automatic t_config();
    host.ctl_write(16'h8ac1, 16'h8b00);
    host.ctl_write(16'h8204, 16'h8300);
    `CHK("saves", 1, saves)
    `CHK("nvcfg", 16'h00c1, nv_config)
    rd_reg(ADDR_CFG, rd);
    `CHK("cfg", 16'h00c1, rd)
    rd_reg(ADDR_MS, rd);
    `CHK("ms_pg3", 16'h0000, rd)
    wr(16'h8000);
    rd_reg(7'h20, rd);
    `CHK("unmapped", 16'h0000, rd)
  endtask : t_config
  // staged write waits for year, then whole load lands
  task automatic t_load();
    wr(16'hf92a);
    rd_reg(ADDR_MS, rd);
    `CHK("staged", 6'h00, rd[13:8])
    host.load_time('{year: 7'h18, month: 4'h6, day: 5'h0f, hour: 5'h0a,
      minute: 6'h2a, second: 6'h05});
    // the load lands on the next tick, which may be up to a second away
    repeat (TL) @(posedge core_clk);
    rd_reg(ADDR_YM, rd);
    `CHK("ym", 16'h1806, rd)
    rd_reg(ADDR_DH, rd);
    `CHK("dh", 16'h0f0a, rd)
    rd_reg(ADDR_MS, rd);
    `CHK("min", 8'h2a, rd[15:8])
    `CHK("sec", 1'b1, (rd[7:0] >= 8'h05) && (rd[7:0] <= 8'h0a))
  endtask : t_load
  // every field but seconds is checked to wrap from its top value
  task automatic t_wrap();
    host.load_time('{year: 7'h63, month: 4'hc, day: 5'h1f, hour: 5'h17,
      minute: 6'h3b, second: 6'h3b});
    // one tick loads the top value, the following tick wraps it
    repeat (2 * TL) @(posedge core_clk);
    rd_reg(ADDR_YM, rd);
    `CHK("ym_wrap", 16'h0001, rd)
    rd_reg(ADDR_DH, rd);
    `CHK("dh_wrap", 16'h0100, rd)
    rd_reg(ADDR_MS, rd);
    `CHK("min_wrap", 8'h00, rd[15:8])
  endtask : t_wrap

  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    stop_test();
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    main_ready = 1'b1;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_not_ready();
    t_page();
    t_elapsed();
    t_config();
    t_load();
    t_wrap();
    stop_test();
  end
endmodule : rtc_timekeeper_test
`default_nettype wire
